// ---- verilog/upc_top.sv ----
// top: usb phy control and power signalling registers with resume detection
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module upc_top
    import upc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic [1:0] line_state,
    input wire logic suspended,
    output logic [1:0] line_state_filt,
    output logic resume_req,
    output logic pulldown_dis,
    output logic [2:0] phy_config_inputs,
    output logic [7:0] power_sig_data,
    output logic power_sig_valid,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] ps_data_reg;
    logic ps_valid_reg;
    logic pd_dis_reg;
    logic rst_res_reg;
    logic k_res_reg;
    logic [3:0] filt_exp_reg;
    logic auto_res_reg;
    logic [2:0] conf_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [1:0] filt_line;
    logic filt_changed;
    logic rst_resume;
    logic k_resume;
    logic wr_ps;
    logic wr_pc;
    logic wr_st;
    logic wr_mk;

    assign wr_ps = wr && addr == OFS_POWER_SIG;
    assign wr_pc = wr && addr == OFS_PHY_CTRL;
    assign wr_st = wr && addr == OFS_IRQ_STATUS;
    assign wr_mk = wr && addr == OFS_IRQ_MASK;

    ////////////////////////////////////////////////////////////////////////////////
    upc_line_filter u_filter (
        .clk(clk),
        .arst_n(arst_n),
        .line_raw(line_state),
        .filt_exp(filt_exp_reg),
        .line_filt(filt_line),
        .changed(filt_changed)
    );

    upc_resume_ctrl u_resume (
        .clk(clk),
        .arst_n(arst_n),
        .auto_en(auto_res_reg),
        .suspended(suspended),
        .line_filt(filt_line),
        .changed(filt_changed),
        .rst_resume(rst_resume),
        .k_resume(k_resume)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // power signalling
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ps_data_reg <= '0;
            ps_valid_reg <= 1'b0;
        end else if (wr_ps) begin
            ps_data_reg <= wdata[PS_DATA_HI:PS_DATA_LO];
            ps_valid_reg <= wdata[PS_VALID_BIT];
        end
    end

    // phy control plain fields
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pd_dis_reg <= 1'b0;
            filt_exp_reg <= '0;
            auto_res_reg <= 1'b0;
            conf_reg <= '0;
        end else if (wr_pc) begin
            pd_dis_reg <= wdata[PC_PD_DIS_BIT];
            filt_exp_reg <= wdata[PC_FILT_HI:PC_FILT_LO];
            auto_res_reg <= wdata[PC_AUTO_RES_BIT];
            conf_reg <= wdata[PC_CONF_HI:PC_CONF_LO];
        end
    end

    // resume kind flags: a set in the same cycle as a clearing write wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_res_reg <= 1'b0;
            k_res_reg <= 1'b0;
        end else begin
            if (rst_resume) begin
                rst_res_reg <= 1'b1;
            end else if (wr_pc && !wdata[PC_RST_RES_BIT]) begin
                rst_res_reg <= 1'b0;
            end
            if (k_resume) begin
                k_res_reg <= 1'b1;
            end else if (wr_pc && !wdata[PC_K_RES_BIT]) begin
                k_res_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write one to clear, set beats clear
    logic [IRQ_W-1:0] irq_events;
    assign irq_events = {filt_changed, k_resume, rst_resume};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~(wr_st ? wdata[IRQ_W-1:0] : '0)) | irq_events;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_reg <= '0;
        end else if (wr_mk) begin
            irq_mask_reg <= wdata[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port: data valid the cycle after rd, zero otherwise and for unmapped addresses
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = ZERO_WORD;
        case (addr)
            OFS_POWER_SIG: begin
                rd_mux[PS_VALID_BIT] = ps_valid_reg;
                rd_mux[PS_DATA_HI:PS_DATA_LO] = ps_data_reg;
            end
            OFS_PHY_CTRL: begin
                rd_mux[PC_PD_DIS_BIT] = pd_dis_reg;
                rd_mux[PC_RST_RES_BIT] = rst_res_reg;
                rd_mux[PC_K_RES_BIT] = k_res_reg;
                rd_mux[PC_FILT_HI:PC_FILT_LO] = filt_exp_reg;
                rd_mux[PC_AUTO_RES_BIT] = auto_res_reg;
                rd_mux[PC_CONF_HI:PC_CONF_LO] = conf_reg;
            end
            OFS_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_reg;
            OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
            OFS_LINE_STATUS: rd_mux[1:0] = filt_line;
            default: rd_mux = ZERO_WORD;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= ZERO_WORD;
        end else begin
            rdata <= rd ? rd_mux : ZERO_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all registered; one cycle behind their source registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulldown_dis <= 1'b0;
            phy_config_inputs <= '0;
            power_sig_data <= '0;
            power_sig_valid <= 1'b0;
            line_state_filt <= LS_J;
            resume_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            pulldown_dis <= pd_dis_reg;
            phy_config_inputs <= conf_reg;
            power_sig_data <= ps_data_reg;
            power_sig_valid <= ps_valid_reg;
            line_state_filt <= filt_line;
            resume_req <= rst_resume | k_resume;
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end
endmodule : upc_top

// ---- verilog/upc_pkg.sv ----
// package: register map, field positions and constants of the usb phy control block
package upc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte addresses
    localparam logic [7:0] OFS_POWER_SIG = 8'h3c;
    localparam logic [7:0] OFS_PHY_CTRL = 8'h40;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h44;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
    localparam logic [7:0] OFS_LINE_STATUS = 8'h4c;
    // power signalling fields
    localparam int PS_VALID_BIT = 8;
    localparam int PS_DATA_HI = 7;
    localparam int PS_DATA_LO = 0;
    // phy control fields
    localparam int PC_PD_DIS_BIT = 18;
    localparam int PC_RST_RES_BIT = 13;
    localparam int PC_K_RES_BIT = 12;
    localparam int PC_FILT_HI = 11;
    localparam int PC_FILT_LO = 8;
    localparam int PC_AUTO_RES_BIT = 7;
    localparam int PC_CONF_HI = 6;
    localparam int PC_CONF_LO = 4;
    // interrupt status / mask bits
    localparam int IRQ_W = 3;
    localparam int IRQ_RST_RES = 0;
    localparam int IRQ_K_RES = 1;
    localparam int IRQ_LINE_CHG = 2;
    // line state codes
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J = 2'h1;
    localparam logic [1:0] LS_K = 2'h2;
    localparam int FILT_CNT_W = 16;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : upc_pkg

// ---- verilog/upc_line_filter.sv ----
// line state filter: passes a change only after it has held for 2^exp clocks, or for 2 clocks when exp is 0
`timescale 1ns/100ps
module upc_line_filter
    import upc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [1:0] line_raw,
    input wire logic [3:0] filt_exp,
    output logic [1:0] line_filt,
    output logic changed
);
    logic [FILT_CNT_W-1:0] cnt_reg;
    logic [FILT_CNT_W:0] limit;

    assign limit = (FILT_CNT_W+1)'(1) << filt_exp;

    // restart the count whenever the raw state disagrees with the last sample
    logic [1:0] last_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_reg <= LS_J;
            cnt_reg <= '0;
            line_filt <= LS_J;
            changed <= 1'b0;
        end else begin
            last_reg <= line_raw;
            changed <= 1'b0;
            if (line_raw != last_reg || line_raw == line_filt) begin
                cnt_reg <= '0;
            end else if ({1'b0, cnt_reg} + (FILT_CNT_W+1)'(2) >= limit) begin
                line_filt <= line_raw;
                changed <= 1'b1;
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + FILT_CNT_W'(1);
            end
        end
    end
endmodule : upc_line_filter

// ---- verilog/upc_resume_ctrl.sv ----
// suspend controller: classifies a resume seen on the filtered line while suspended
`timescale 1ns/100ps
module upc_resume_ctrl
    import upc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic auto_en,
    input wire logic suspended,
    input wire logic [1:0] line_filt,
    input wire logic changed,
    output logic rst_resume,
    output logic k_resume
);
    // one-cycle pulses; only the first filtered change after suspend counts,
    // so a long resume is never reported twice until suspend is entered again or auto_en is cleared and set again
    logic armed_reg;
    logic spent_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_reg <= 1'b0;
            spent_reg <= 1'b0;
            rst_resume <= 1'b0;
            k_resume <= 1'b0;
        end else begin
            rst_resume <= 1'b0;
            k_resume <= 1'b0;
            if (!auto_en || !suspended) begin
                armed_reg <= 1'b0;
                spent_reg <= 1'b0;
            end else if (!armed_reg && !spent_reg) begin
                armed_reg <= 1'b1;
            end else if (armed_reg && changed) begin
                armed_reg <= 1'b0;
                spent_reg <= 1'b1;
                rst_resume <= (line_filt == LS_SE0);
                k_resume <= (line_filt == LS_K);
            end
        end
    end
endmodule : upc_resume_ctrl

// ---- testbench/upc_monitor.sv ----
// checker: port-level timing relations of the usb phy control block
`timescale 1ns/100ps
module upc_monitor
    import upc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] line_state,
    input wire logic [1:0] line_state_filt,
    input wire logic resume_req,
    input wire logic pulldown_dis,
    input wire logic [2:0] phy_config_inputs,
    input wire logic [7:0] power_sig_data,
    input wire logic power_sig_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic wr_pc = wr && addr == OFS_PHY_CTRL;
    wire logic wr_ps = wr && addr == OFS_POWER_SIG;
    ////////////////////////////////////////////////////////////////////////////////
    // outputs lag the write by two register stages; a following write supersedes it
    property p_pd; logic v; (wr_pc, v = wdata[18]) ##1 !wr_pc |-> ##1 pulldown_dis == v;
    endproperty
    a_pd: assert property (p_pd) else $error("pulldown disable not taken");
    property p_cfg; logic [2:0] v;
        (wr_pc, v = wdata[6:4]) ##1 !wr_pc |-> ##1 phy_config_inputs == v;
    endproperty
    a_cfg: assert property (p_cfg) else $error("config pins not taken");
    property p_psd; logic [7:0] v;
        (wr_ps, v = wdata[7:0]) ##1 !wr_ps |-> ##1 power_sig_data == v;
    endproperty
    a_psd: assert property (p_psd) else $error("power data not taken");
    property p_psv; logic v; (wr_ps, v = wdata[8]) ##1 !wr_ps |-> ##1 power_sig_valid == v;
    endproperty
    a_psv: assert property (p_psv) else $error("power valid not taken");
    property p_filt; $changed(line_state_filt) |-> line_state_filt == $past(line_state, 2);
    endproperty
    a_filt: assert property (p_filt) else $error("filtered state not from held line");
    property p_pulse; resume_req |=> !resume_req; endproperty
    a_pulse: assert property (p_pulse) else $error("resume request too long");
    property p_cls; resume_req |-> line_state_filt != LS_J; endproperty
    a_cls: assert property (p_cls) else $error("resume on idle line");
    property p_rdz; !$past(rd) |-> rdata == ZERO_WORD; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside read slot");
    c_wr: cover property (wr_pc);
    c_res: cover property (resume_req);
    c_filt: cover property ($changed(line_state_filt));
endmodule : upc_monitor

// ---- testbench/upc_phy_model.sv ----
// partner model: line state and suspend indication of the transceiver
`timescale 1ns/100ps
module upc_phy_model (
    input wire logic clk,
    output logic [1:0] line_state,
    output logic suspended
);
    initial begin
        line_state = 2'h1;
        suspended = 1'b0;
    end
    // short holds make glitches that the filter must drop
    task automatic drive(input logic [1:0] s, input int n);
        @(posedge clk);
        line_state <= s;
        repeat (n - 1) @(posedge clk);
    endtask : drive
    task automatic set_susp(input logic v);
        @(posedge clk);
        suspended <= v;
    endtask : set_susp
endmodule : upc_phy_model

// ---- testbench/upc_top_tb.sv ----
// testbench: registers, line filter, resume and interrupt of the usb phy control block
`timescale 1ns/100ps
module upc_top_tb;
    import upc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, d;
    logic [31:0] phy = 32'h0000_0000;
    logic [31:0] ps = 32'h0000_0000;
    logic [31:0] sts = 32'h0000_0000;
    logic [1:0] line_state, line_state_filt;
    logic suspended, resume_req, pulldown_dis, power_sig_valid, irq;
    logic [2:0] phy_config_inputs;
    logic [7:0] power_sig_data;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    upc_top u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .line_state(line_state), .suspended(suspended),
        .line_state_filt(line_state_filt), .resume_req(resume_req), .pulldown_dis(pulldown_dis),
        .phy_config_inputs(phy_config_inputs), .power_sig_data(power_sig_data),
        .power_sig_valid(power_sig_valid), .irq(irq));
    upc_phy_model u_phy (.clk(clk), .line_state(line_state), .suspended(suspended));
    initial begin
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // the reference model tracks the power, phy control and interrupt status registers as software should see them
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        case (a)
            OFS_POWER_SIG: ps = v & 32'h0000_01ff;
            OFS_PHY_CTRL: phy = (v & 32'h0004_0ff0) | (phy & v & 32'h0000_3000);
            OFS_IRQ_STATUS: sts = sts & ~v;
            default: ;
        endcase
    endtask : wr_reg
    task automatic rd_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask : rd_reg
    task automatic wait_filt(input logic [1:0] ls);
        n = 0;
        while (line_state_filt !== ls && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (line_state_filt !== ls) begin
            mismatches++;
            stop_test();
        end
    endtask : wait_filt
    task automatic count_resume(input logic [31:0] e);
        n = 0;
        repeat (10) begin
            @(posedge clk);
            #1;
            n += resume_req;
        end
        chk("resume pulses", e, n);
    endtask : count_resume
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", e, irq);
    endtask : irq_chk
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(74005));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rd_reg("power reset", OFS_POWER_SIG, ps);
        rd_reg("phy reset", OFS_PHY_CTRL, phy);
        repeat (4) begin
            d = $urandom();
            wr_reg(OFS_POWER_SIG, d);
            wr_reg(OFS_PHY_CTRL, d);
            wr_reg(8'h50, d);
            rd_reg("power", OFS_POWER_SIG, ps);
            rd_reg("phy", OFS_PHY_CTRL, phy);
            rd_reg("unmapped", 8'h50, 32'h0000_0000);
            chk("pulldown", phy[18], pulldown_dis);
            chk("config", phy[6:4], phy_config_inputs);
            chk("power port", ps[8:0], {power_sig_valid, power_sig_data});
        end
        // mid-run reset: the power and phy control registers and their outputs must fall back to zero
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pulldown in reset", 32'h0000_0000, pulldown_dis);
        chk("config in reset", 32'h0000_0000, phy_config_inputs);
        chk("power in reset", 32'h0000_0000, {power_sig_valid, power_sig_data});
        arst_n <= 1'b1;
        ps = 32'h0000_0000;
        phy = 32'h0000_0000;
        rd_reg("power mid reset", OFS_POWER_SIG, ps);
        rd_reg("phy mid reset", OFS_PHY_CTRL, phy);
        for (int e = 1; e <= 3; e++) begin
            wr_reg(OFS_PHY_CTRL, e << 8);
            u_phy.drive(LS_K, (1 << e) - 1);
            u_phy.drive(LS_J, 12);
            chk("glitch", LS_J, line_state_filt);
            u_phy.drive(LS_K, 1);
            wait_filt(LS_K);
            chk("filter delay", 1, n >= (1 << e) && n <= (1 << e) + 3);
            u_phy.drive(LS_J, 1);
            wait_filt(LS_J);
        end
        sts = 32'h0000_0004;
        rd_reg("line status", OFS_IRQ_STATUS, sts);
        irq_chk(1'b0);
        wr_reg(OFS_IRQ_MASK, 32'h0000_0004);
        irq_chk(1'b1);
        wr_reg(OFS_IRQ_STATUS, 32'h0000_0004);
        irq_chk(1'b0);
        wr_reg(OFS_IRQ_MASK, 32'h0000_0003);
        wr_reg(OFS_PHY_CTRL, 32'h0000_0180);
        for (int k = 0; k < 2; k++) begin
            u_phy.set_susp(1'b1);
            u_phy.drive(k ? LS_SE0 : LS_K, 2);
            count_resume(1);
            phy = phy | (32'h0000_1000 << k);
            sts = sts | (k ? 32'h0000_0005 : 32'h0000_0006);
            rd_reg("resume flag", OFS_PHY_CTRL, phy);
            rd_reg("resume status", OFS_IRQ_STATUS, sts);
            chk("irq resume", 1, irq);
            wr_reg(OFS_PHY_CTRL, 32'h0000_3180);
            rd_reg("sticky flag", OFS_PHY_CTRL, phy);
            wr_reg(OFS_PHY_CTRL, 32'h0000_0180);
            wr_reg(OFS_IRQ_STATUS, 32'h0000_0007);
            u_phy.set_susp(1'b0);
            u_phy.drive(LS_J, 8);
            sts = 32'h0000_0004;
        end
        wr_reg(OFS_PHY_CTRL, 32'h0000_0100);
        u_phy.set_susp(1'b1);
        u_phy.drive(LS_K, 2);
        count_resume(0);
        rd_reg("line poll", OFS_LINE_STATUS, 32'h0000_0002);
        rd_reg("no flag", OFS_PHY_CTRL, phy);
        stop_test();
    end
endmodule : upc_top_tb
bind upc_top upc_monitor u_mon (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .line_state(line_state), .line_state_filt(line_state_filt),
    .resume_req(resume_req), .pulldown_dis(pulldown_dis), .phy_config_inputs(phy_config_inputs),
    .power_sig_data(power_sig_data), .power_sig_valid(power_sig_valid));
